/* urc_ctrl.sv */
`timescale 1ns/1ns
module urc_ctrl #(
  parameter int LEVEL_W = 9
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [7:0] modem_status_i,
  input wire urc_pkg::urc_tx_ev_t tx_ev_i,
  input wire urc_pkg::urc_rx_ev_t rx_ev_i,
  input wire logic bit_tick_i,
  input wire logic [LEVEL_W-1:0] rx_level_i,
  input wire logic [LEVEL_W-1:0] rx_trig_i,
  input wire logic [LEVEL_W-1:0] next_up_i,
  input wire logic [LEVEL_W-1:0] next_dn_i,
  input wire logic ir_rx_i,
  output logic tx_halt_o,
  output logic xchar_allow_o,
  output logic rx_data_en_o,
  output logic rx_xchar_en_o,
  output logic tx_irq_src_o,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic dir_o,
  output logic ir_rx_o,
  output logic [1:0] trig_table_o
);
  import urc_pkg::*;
  if (LEVEL_W < 7 || LEVEL_W > 16) begin : g_chk
    $error("LEVEL_W must be 7 to 16");
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ****************************************
  // APB slave
  // ****************************************
  logic [7:0] ddc_reg;
  logic [7:0] spr_reg;
  logic [7:0] feature_control_reg;
  logic [7:0] efr_reg;
  logic [7:0] mcr_reg;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic [7:0] rd_mux;
  logic [7:0] wbyte;
  assign setup = psel_i && !penable_i && !pready_o;
  assign access = psel_i && penable_i && pready_o;
  assign wr = access && pwrite_i && !pslverr_o && pstrb_i[0];
  assign wbyte = pwdata_i[7:0];
  always_comb begin
    mapped = 1'b1;
    rd_mux = 8'h00;
    case (paddr_i)
      URC_OFS_DDC: rd_mux = modem_status_i;
      URC_OFS_SPR: rd_mux = spr_reg;
      URC_OFS_FEATURE_CONTROL: rd_mux = feature_control_reg;
      URC_OFS_EFR: rd_mux = efr_reg;
      URC_OFS_MCR: rd_mux = mcr_reg;
      default: mapped = 1'b0;
    endcase
  end
  // Zero wait: answer is prepared in setup so pready can come from a flop
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= setup;
      pslverr_o <= setup && !mapped;
      if (setup && !pwrite_i) begin
        prdata_o <= {24'h000000, rd_mux};
      end
    end
  end
  // ****************************************
  // Control registers
  // ****************************************
  // Legacy software cannot disturb the enhanced bits once the gate is closed
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ddc_reg <= URC_RST_CTL;
    end else if (wr && paddr_i == URC_OFS_DDC && efr_reg[URC_EFR_ENH]) begin
      ddc_reg <= wbyte;
    end
  end

  // No reset source other than rst_i, so the content survives sleep
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      spr_reg <= URC_RST_SPR;
    end else if (wr && paddr_i == URC_OFS_SPR) begin
      spr_reg <= wbyte;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      feature_control_reg <= URC_RST_CTL;
      efr_reg <= URC_RST_CTL;
      mcr_reg <= URC_RST_CTL;
    end else begin
      if (wr && paddr_i == URC_OFS_FEATURE_CONTROL) begin
        feature_control_reg <= wbyte;
      end
      if (wr && paddr_i == URC_OFS_EFR) begin
        efr_reg <= wbyte;
      end
      if (wr && paddr_i == URC_OFS_MCR) begin
        mcr_reg <= wbyte;
      end
    end
  end

  logic auto485;
  logic tx_dis;
  logic rx_dis;
  logic [3:0] dly;
  assign auto485 = feature_control_reg[URC_FEATURE_CONTROL_485];
  assign tx_dis = ddc_reg[URC_DDC_TXDIS];
  assign rx_dis = ddc_reg[URC_DDC_RXDIS];
  assign dly = ddc_reg[URC_DDC_DLY_LSB +: 4];
  // ****************************************
  // Transmit and receive disable
  // ****************************************
  logic tx_dis_d_reg;
  logic token_reg;
  logic rx_on_reg;
  logic token_next;
  logic rx_on_next;

  // Set wins over the clear when a pending character meets the disable edge
  assign token_next = tx_dis && ((!tx_dis_d_reg && tx_ev_i.xchar_pend) ||
                      (token_reg && !tx_ev_i.xchar_sent));
  // Character in progress finishes before reception stops
  assign rx_on_next = !rx_dis || (rx_on_reg && rx_ev_i.busy && !rx_ev_i.done);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_dis_d_reg <= 1'b0;
      token_reg <= 1'b0;
      rx_on_reg <= 1'b1;
    end else begin
      tx_dis_d_reg <= tx_dis;
      token_reg <= token_next;
      rx_on_reg <= rx_on_next;
    end
  end

  // Immediate send is not gated here; software must keep tx_dis clear for it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tx_halt_o <= 1'b0;
      xchar_allow_o <= 1'b1;
      rx_data_en_o <= 1'b1;
      rx_xchar_en_o <= 1'b1;
    end else begin
      tx_halt_o <= tx_dis;
      xchar_allow_o <= !tx_dis || ddc_reg[URC_DDC_TXMODE] || token_next;
      rx_data_en_o <= rx_on_next;
      rx_xchar_en_o <= rx_on_next || ddc_reg[URC_DDC_RXMODE];
    end
  end
  // Receive FIFO read path is outside this gating and stays open
  // ****************************************
  // RS-485 direction
  // ****************************************
  urc_dir_st_t st_reg;
  urc_dir_st_t st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic dir_reg;
  logic tx_done;

  // Only data loads raise the pin; flow characters never do
  assign tx_done = tx_ev_i.tsr_empty && tx_ev_i.txf_empty && !tx_ev_i.tx_load;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      URC_DIR_RX: begin
        if (auto485 && tx_ev_i.tx_load) begin
          st_next = URC_DIR_TX;
        end
      end
      URC_DIR_TX: begin
        if (tx_done) begin
          cnt_next = dly;
          st_next = (dly == 4'h0) ? URC_DIR_RX : URC_DIR_TURN;
        end
      end
      URC_DIR_TURN: begin
        if (tx_ev_i.tx_load) begin
          st_next = URC_DIR_TX;
        end else if (bit_tick_i) begin
          cnt_next = cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            st_next = URC_DIR_RX;
          end
        end
      end
      default: st_next = URC_DIR_RX;
    endcase
    if (!auto485) begin
      st_next = URC_DIR_RX;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_reg <= URC_DIR_RX;
      cnt_reg <= 4'h0;
      dir_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      dir_reg <= (st_next != URC_DIR_RX);
    end
  end
  // ****************************************
  // Receive flow control thresholds
  // ****************************************
  logic [5:0] hyst;
  logic use_hyst;
  logic [LEVEL_W:0] upper;
  logic [LEVEL_W:0] lower;
  logic flow_hold_reg;
  logic flow_next;

  assign hyst = urc_hyst(feature_control_reg[3:0]);
  assign use_hyst = (feature_control_reg[URC_FEATURE_CONTROL_TBL_LSB +: 2] == URC_TBL_D) && (hyst != 6'h00);

  always_comb begin
    if (use_hyst) begin
      upper = {1'b0, rx_trig_i} + (LEVEL_W+1)'(hyst);
      lower = (rx_trig_i > LEVEL_W'(hyst)) ?
              {1'b0, rx_trig_i - LEVEL_W'(hyst)} : '0;
    end else begin
      upper = {1'b0, next_up_i};
      lower = {1'b0, next_dn_i};
    end
    flow_next = flow_hold_reg;
    if ({1'b0, rx_level_i} >= upper) begin
      flow_next = 1'b1;
    end else if ({1'b0, rx_level_i} < lower) begin
      flow_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flow_hold_reg <= 1'b0;
    end else begin
      flow_hold_reg <= flow_next;
    end
  end
  // ****************************************
  // Modem control pins
  // ****************************************
  logic sel_pin;
  logic sel_base;
  logic auto_pin;
  assign sel_pin = mcr_reg[URC_MCR_SEL];
  assign sel_base = sel_pin ? mcr_reg[URC_MCR_DTR] : mcr_reg[URC_MCR_RTS];

  // Pin is high while transmitting; direction wins over flow control
  always_comb begin
    if (auto485) begin
      auto_pin = (st_next != URC_DIR_RX);
    end else if (efr_reg[URC_EFR_ARTS]) begin
      auto_pin = flow_next || !sel_base;
    end else begin
      auto_pin = !sel_base;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
      dir_o <= 1'b0;
      tx_irq_src_o <= 1'b1;
      trig_table_o <= 2'h0;
    end else begin
      rts_n_o <= sel_pin ? !mcr_reg[URC_MCR_RTS] : auto_pin;
      dtr_n_o <= sel_pin ? auto_pin : !mcr_reg[URC_MCR_DTR];
      dir_o <= (st_next != URC_DIR_RX);
      tx_irq_src_o <= auto485 ? tx_ev_i.tsr_empty : tx_ev_i.thr_empty;
      trig_table_o <= feature_control_reg[URC_FEATURE_CONTROL_TBL_LSB +: 2];
    end
  end
  // ****************************************
  // Infrared receive input
  // ****************************************
  logic ir_s1_reg;
  logic ir_s2_reg;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ir_s1_reg <= 1'b0;
      ir_s2_reg <= 1'b0;
      ir_rx_o <= 1'b0;
    end else begin
      ir_s1_reg <= ir_rx_i;
      ir_s2_reg <= ir_s1_reg;
      ir_rx_o <= ir_s2_reg ^ feature_control_reg[URC_FEATURE_CONTROL_IRINV];
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  property p_turn_load;
    (st_reg == URC_DIR_TX && tx_done && auto485 && dly != 4'h0) |=>
      (st_reg == URC_DIR_TURN && cnt_reg == $past(dly));
  endproperty
  a_turn_load: assert property (p_turn_load) else $error("turnaround count not loaded");
  property p_turn_end;
    (st_reg == URC_DIR_TURN && cnt_reg == 4'h1 && bit_tick_i && !tx_ev_i.tx_load && auto485)
      |=> !dir_reg && !dir_o;
  endproperty
  a_turn_end: assert property (p_turn_end) else $error("direction not released");
  property p_ddc_locked;
    (wr && paddr_i == URC_OFS_DDC && !efr_reg[URC_EFR_ENH]) |=> $stable(ddc_reg);
  endproperty
  a_ddc_locked: assert property (p_ddc_locked) else $error("locked field written");
  property p_tx_halt;
    (wr && paddr_i == URC_OFS_DDC && efr_reg[URC_EFR_ENH]) |=>
      ##1 (tx_halt_o == $past(wbyte[URC_DDC_TXDIS], 2));
  endproperty
  a_tx_halt: assert property (p_tx_halt) else $error("halt does not follow write");
  property p_rx_stop;
    (rx_dis && !rx_ev_i.busy) |=> !rx_data_en_o;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("receiver not stopped");
  property p_xchar_block;
    (tx_dis && tx_dis_d_reg && !ddc_reg[URC_DDC_TXMODE] && !token_reg) |=> !xchar_allow_o;
  endproperty
  a_xchar_block: assert property (p_xchar_block) else $error("extra flow char allowed");
  property p_rx_xchar;
    (rx_dis && ddc_reg[URC_DDC_RXMODE]) |=> rx_xchar_en_o && (!rx_data_en_o || rx_on_reg);
  endproperty
  a_rx_xchar: assert property (p_rx_xchar) else $error("flow char detect lost");
  property p_dir_rise;
    (st_reg == URC_DIR_RX && auto485 && tx_ev_i.tx_load) |=> dir_reg && dir_o;
  endproperty
  a_dir_rise: assert property (p_dir_rise) else $error("direction not raised");
  property p_irq_src;
    (auto485 && !tx_ev_i.tsr_empty) |=> !tx_irq_src_o;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("wrong transmit irq source");
  property p_pin_prec;
    (auto485 && !mcr_reg[URC_MCR_SEL]) |=> (rts_n_o == dir_reg);
  endproperty
  a_pin_prec: assert property (p_pin_prec) else $error("direction lost precedence");
  // Synchroniser holds reset values for two edges, so the check waits them out
  property p_ir_pol;
    ($stable(feature_control_reg) && !$past(rst_i) && !$past(rst_i, 2)) |=>
      (ir_rx_o == ($past(ir_rx_i, 3) ^ $past(feature_control_reg[URC_FEATURE_CONTROL_IRINV])));
  endproperty
  a_ir_pol: assert property (p_ir_pol) else $error("infrared polarity wrong");
  c_turn: cover property (st_reg == URC_DIR_TURN ##[1:300] st_reg == URC_DIR_RX);
  c_token: cover property (token_reg && tx_ev_i.xchar_sent);
  c_rx_mid: cover property (rx_dis && rx_on_reg && rx_ev_i.done);
  c_hyst: cover property (use_hyst && flow_next && !flow_hold_reg);
endmodule

/* urc_pkg.sv */
package urc_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] URC_OFS_DDC = 8'h00;
  localparam logic [7:0] URC_OFS_SPR = 8'h04;
  localparam logic [7:0] URC_OFS_FEATURE_CONTROL = 8'h08;
  localparam logic [7:0] URC_OFS_EFR = 8'h0C;
  localparam logic [7:0] URC_OFS_MCR = 8'h10;
  localparam logic [7:0] URC_RST_SPR = 8'hFF;
  localparam logic [7:0] URC_RST_CTL = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int URC_DDC_DLY_LSB = 4;
  localparam int URC_DDC_TXDIS = 3;
  localparam int URC_DDC_RXDIS = 2;
  localparam int URC_DDC_TXMODE = 1;
  localparam int URC_DDC_RXMODE = 0;
  localparam int URC_FEATURE_CONTROL_TBL_LSB = 6;
  localparam int URC_FEATURE_CONTROL_485 = 5;
  localparam int URC_FEATURE_CONTROL_IRINV = 4;
  localparam int URC_EFR_ARTS = 6;
  localparam int URC_EFR_ENH = 4;
  localparam int URC_MCR_SEL = 2;
  localparam int URC_MCR_RTS = 1;
  localparam int URC_MCR_DTR = 0;
  localparam logic [1:0] URC_TBL_D = 2'h3;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic tx_load;
    logic tsr_empty;
    logic thr_empty;
    logic txf_empty;
    logic xchar_pend;
    logic xchar_sent;
  } urc_tx_ev_t;
  typedef struct packed {
    logic busy;
    logic done;
  } urc_rx_ev_t;
  typedef enum logic [1:0] {URC_DIR_RX, URC_DIR_TX, URC_DIR_TURN} urc_dir_st_t;
  function automatic logic [5:0] urc_hyst(input logic [3:0] code);
    case (code)
      4'h0: urc_hyst = 6'h00;
      4'h1: urc_hyst = 6'h04;
      4'h2: urc_hyst = 6'h06;
      4'h3: urc_hyst = 6'h08;
      4'h4: urc_hyst = 6'h08;
      4'h5: urc_hyst = 6'h10;
      4'h6: urc_hyst = 6'h18;
      4'h7: urc_hyst = 6'h20;
      4'h8: urc_hyst = 6'h28;
      4'h9: urc_hyst = 6'h2C;
      4'hA: urc_hyst = 6'h30;
      4'hB: urc_hyst = 6'h34;
      4'hC: urc_hyst = 6'h0C;
      4'hD: urc_hyst = 6'h14;
      4'hE: urc_hyst = 6'h1C;
      default: urc_hyst = 6'h24;
    endcase
  endfunction
endpackage

/* urc_line_model.sv */
`timescale 1ns/1ns
module urc_line_model #(
  parameter int TICK_DIV = 4,
  parameter int FRAME_BITS = 10
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic tx_halt_i,
  input wire logic load_i,
  input wire logic xchar_pend_i,
  input wire logic xchar_sent_i,
  output urc_pkg::urc_tx_ev_t tx_ev_o,
  output logic bit_tick_o
);
  import urc_pkg::*;
  // ****************************************
  // Transmitter seen from the line: one frame per queued byte
  // ****************************************
  logic [2:0] div_reg;
  logic [7:0] fifo_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic busy_reg;
  logic start;
  assign bit_tick_o = (div_reg == 3'(TICK_DIV - 1));
  // A frozen shifter never starts a frame, so queued bytes wait
  assign start = bit_tick_o && !busy_reg && (fifo_cnt_reg != 8'h00) && !tx_halt_i;
  assign tx_ev_o = '{tx_load: load_i, tsr_empty: !busy_reg, thr_empty: fifo_cnt_reg == 8'h00,
                     txf_empty: fifo_cnt_reg == 8'h00, xchar_pend: xchar_pend_i,
                     xchar_sent: xchar_sent_i};
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || bit_tick_o) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fifo_cnt_reg <= 8'h00;
    end else begin
      fifo_cnt_reg <= fifo_cnt_reg + {7'h00, load_i} - {7'h00, start};
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end else if (start) begin
      busy_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
    end else if (busy_reg && bit_tick_o) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == 4'(FRAME_BITS - 1)) begin
        busy_reg <= 1'b0;
      end
    end
  end
endmodule

/* urc_ctrl_tb_top.sv */
`timescale 1ns/1ns
module urc_ctrl_tb_top;
  import urc_pkg::*;
  // ****************************************
  // Stimulus, expectations and checking
  // ****************************************
  localparam logic [5:0] HYS [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
                                      6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
  localparam logic [3:0] DLY [4] = '{4'h0, 4'h1, 4'h7, 4'hF};
  logic clk_sys_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, err, load = 1'b0, xpend = 1'b0, xsent = 1'b0, tick, ir = 1'b1;
  logic halt, xallow, rxd_en, rxx_en, irq_src, rts_n, dtr_n, dir, ir_out, pin;
  logic [1:0] tbl;
  logic [7:0] paddr = 8'h00, msr_in = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'hBC905EC4;
  logic [8:0] lvl = 9'h000, trig = 9'h064, up = 9'h078, dn = 9'h050, hi, lo;
  urc_rx_ev_t rx_ev = '0;
  urc_tx_ev_t tx_ev;
  int miscompares = 0, n_checks = 0, cycles = 0, cnt, t;
  urc_ctrl urc_ctrl_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .modem_status_i(msr_in), .tx_ev_i(tx_ev),
    .rx_ev_i(rx_ev), .bit_tick_i(tick), .rx_level_i(lvl), .rx_trig_i(trig), .next_up_i(up),
    .next_dn_i(dn), .ir_rx_i(ir), .tx_halt_o(halt), .xchar_allow_o(xallow),
    .rx_data_en_o(rxd_en), .rx_xchar_en_o(rxx_en), .tx_irq_src_o(irq_src), .rts_n_o(rts_n),
    .dtr_n_o(dtr_n), .dir_o(dir), .ir_rx_o(ir_out), .trig_table_o(tbl));
  urc_line_model urc_line_model_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tx_halt_i(halt),
    .load_i(load), .xchar_pend_i(xpend), .xchar_sent_i(xsent), .tx_ev_o(tx_ev),
    .bit_tick_o(tick));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Code 0 falls back to the next table level up and down
  function automatic logic [8:0] lim(input logic [3:0] c, input logic upper);
    if (c == 4'h0) return upper ? up : dn;
    if (upper) return trig + 9'(HYS[c]);
    return (trig > 9'(HYS[c])) ? trig - 9'(HYS[c]) : 9'h000;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // Wait ends once pready is high; the hang guard stops a slave that never answers
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic send_byte();
    load <= 1'b1;
    @(posedge clk_sys_i);
    load <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // Hang guard: the whole sequence needs well under 5000 cycles
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("dir_rst", dir, 1'b0);
    chk("rx_en_rst", rxd_en, 1'b1);
    apb(1'b0, URC_OFS_SPR, 8'h00);
    chk("spr_rst", rd, 32'h000000FF);
    apb(1'b0, URC_OFS_FEATURE_CONTROL, 8'h00);
    chk("feature_control_rst", rd, 32'h00000000);
    for (int i = 0; i < 6; i++) begin
      v = xs();
      apb(1'b1, URC_OFS_SPR, v[7:0]);
      apb(1'b0, URC_OFS_SPR, 8'h00);
      chk("spr", rd, {24'h000000, v[7:0]});
    end
    apb(1'b0, 8'h14, 8'h00);
    chk("unmapped_err", err, 1'b1);
    apb(1'b1, URC_OFS_DDC, 8'h08);
    settle();
    chk("halt_locked", halt, 1'b0);
    apb(1'b1, URC_OFS_EFR, 8'h10);
    apb(1'b1, URC_OFS_DDC, 8'h08);
    settle();
    chk("halt", halt, 1'b1);
    v = xs();
    msr_in <= v[7:0];
    apb(1'b0, URC_OFS_DDC, 8'h00);
    chk("status_read", rd, {24'h000000, v[7:0]});
    apb(1'b1, URC_OFS_EFR, 8'h00);
    apb(1'b1, URC_OFS_DDC, 8'h00);
    settle();
    chk("halt_latched", halt, 1'b1);
    apb(1'b1, URC_OFS_EFR, 8'h10);
    apb(1'b1, URC_OFS_DDC, 8'h00);
    xpend <= 1'b1;
    apb(1'b1, URC_OFS_DDC, 8'h08);
    settle();
    chk("xchar_pending", xallow, 1'b1);
    xsent <= 1'b1;
    @(posedge clk_sys_i);
    xsent <= 1'b0;
    xpend <= 1'b0;
    settle();
    chk("xchar_after_sent", xallow, 1'b0);
    apb(1'b1, URC_OFS_DDC, 8'h0A);
    settle();
    chk("xchar_mode1", xallow, 1'b1);
    rx_ev <= '{busy: 1'b1, done: 1'b0};
    apb(1'b1, URC_OFS_DDC, 8'h04);
    settle();
    chk("rx_in_progress", rxd_en, 1'b1);
    rx_ev <= '{busy: 1'b0, done: 1'b1};
    @(posedge clk_sys_i);
    rx_ev <= '0;
    settle();
    chk("rx_stopped", rxd_en, 1'b0);
    chk("rx_xchar_mode0", rxx_en, 1'b0);
    apb(1'b1, URC_OFS_DDC, 8'h05);
    settle();
    chk("rx_xchar_mode1", rxx_en, 1'b1);
    chk("rx_data_mode1", rxd_en, 1'b0);
    // Line is idle here, so re-enabling is safe
    apb(1'b1, URC_OFS_DDC, 8'h00);
    settle();
    chk("rx_reenabled", rxd_en, 1'b1);
    apb(1'b1, URC_OFS_FEATURE_CONTROL, 8'h20);
    apb(1'b1, URC_OFS_MCR, 8'h00);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, URC_OFS_DDC, {DLY[i], 4'h0});
      send_byte();
      chk("dir_on_load", dir, 1'b1);
      chk("pin_is_dir", rts_n, 1'b1);
      t = 0;
      while (!(tx_ev.tsr_empty && tx_ev.txf_empty) && t < 400) begin
        @(posedge clk_sys_i);
        t++;
      end
      cnt = 0;
      while (dir === 1'b1 && t < 400) begin
        cnt += int'(tick);
        @(posedge clk_sys_i);
        t++;
      end
      chk("turn_delay", cnt, DLY[i]);
    end
    apb(1'b1, URC_OFS_DDC, 8'h08);
    send_byte();
    settle();
    chk("irq_shift_empty", irq_src, 1'b1);
    apb(1'b1, URC_OFS_FEATURE_CONTROL, 8'h00);
    settle();
    chk("irq_holding_empty", irq_src, 1'b0);
    apb(1'b1, URC_OFS_DDC, 8'h00);
    repeat (80) @(posedge clk_sys_i);
    chk("resume_sent", tx_ev.txf_empty, 1'b1);
    for (int i = 0; i < 8; i++) begin
      v = xs();
      apb(1'b1, URC_OFS_FEATURE_CONTROL, {3'h0, v[0], 4'h0});
      ir <= v[1];
      repeat (5) @(posedge clk_sys_i);
      chk("ir_level", ir_out, v[1] ^ v[0]);
    end
    apb(1'b1, URC_OFS_EFR, 8'h50);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, URC_OFS_MCR, c[0] ? 8'h05 : 8'h02);
      apb(1'b1, URC_OFS_FEATURE_CONTROL, {4'hC, 4'(c)});
      hi = lim(4'(c), 1'b1);
      lo = lim(4'(c), 1'b0);
      lvl <= lo - 9'h001;
      settle();
      pin = c[0] ? dtr_n : rts_n;
      chk("flow_low", pin, 1'b0);
      lvl <= hi - 9'h001;
      settle();
      pin = c[0] ? dtr_n : rts_n;
      chk("flow_below_upper", pin, 1'b0);
      lvl <= hi;
      settle();
      pin = c[0] ? dtr_n : rts_n;
      chk("flow_upper", pin, 1'b1);
      lvl <= lo;
      settle();
      pin = c[0] ? dtr_n : rts_n;
      chk("flow_hold", pin, 1'b1);
      chk("table_d", tbl, 2'h3);
    end
    apb(1'b1, URC_OFS_MCR, 8'h02);
    apb(1'b1, URC_OFS_FEATURE_CONTROL, 8'h45);
    lvl <= 9'h04F;
    settle();
    lvl <= 9'h074;
    settle();
    chk("table_b_no_hyst", rts_n, 1'b0);
    lvl <= up;
    settle();
    chk("table_b_up", rts_n, 1'b1);
    chk("table_b", tbl, 2'h1);
    apb(1'b1, URC_OFS_FEATURE_CONTROL, 8'h20);
    settle();
    chk("auto_dir_wins", rts_n, 1'b0);
    xpend <= 1'b1;
    xsent <= 1'b1;
    settle();
    chk("xchar_no_dir", dir, 1'b0);
    xpend <= 1'b0;
    xsent <= 1'b0;
    close_out();
  end
endmodule
